// >>> motion_status_regs.sv
// motion, key status, displacement and surface quality test registers
// assumes a usb control decoder issues register reads and an endpoint
// engine pulses report_taken when the host has collected a report
//
// How it works
// R1: movement flag reads 1 after movement or a key change since last report, else 0.
// R2: movement flag equals the report endpoint holding unsent data.
// R3: five-key mode: fifth key bit is inverted option-one pin.
// R4: five-key mode: fourth key bit is inverted option-zero pin.
// R5: three primary key bits read 1 for grounded pin, 0 for high.
// R6: key bits come from debounced levels, never from raw pins.
// R7: reserved status bits reset to zero and always read zero.
// R8: x register at 0x03, reset 0x00, holds last sent or queued x.
// R9: y register at 0x04, reset 0x00, holds last sent or queued y.
// R10: both displacements are eight-bit two's complement values.
// R11: displacement magnitude follows the current resolution setting.
// R12: y read without a preceding x read returns zero.
// R13: host uses these only as test aids; navigation uses hid reports.
// R14: host reaches registers through usb requests only.
// R15: movement flag clears once report taken and no new movement or key change is pending.
`timescale 1ns/1ns
`default_nettype none
`include "motion_regs_params.svh"

module motion_status_regs #(
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic left_key_input_n,
  input wire logic right_key_input_n,
  input wire logic middle_key_input_n,
  input wire logic option_select_zero_pin_n,
  input wire logic option_select_one_pin_n,
  input wire logic five_key_mode,
  input wire logic full_resolution,
  input wire logic motion_valid,
  input wire logic [7:0] motion_dx,
  input wire logic [7:0] motion_dy,
  input wire logic [7:0] surface_quality_in,
  input wire logic report_taken,
  input wire logic reg_rd_req,
  input wire logic [7:0] reg_addr,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  output logic report_valid,
  output logic [4:0] report_keys,
  output logic [7:0] report_x,
  output logic [7:0] report_y
);

  motion_regs_pkg::regs_state_t q;
  motion_regs_pkg::regs_state_t d;
  logic [4:0] keys_pressed;
  logic [4:0] keys_now;
  logic [7:0] step_x;
  logic [7:0] step_y;
  logic [7:0] sum_x;
  logic [7:0] sum_y;
  logic pending_now;
  logic ep_free;

  key_debounce_if kif ();

  // saturating signed add keeps a large move from wrapping its sign
  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {a[7], a} + {b[7], b};
    if (s[8] != s[7]) begin
      sat_add = s[8] ? 8'h80 : 8'h7f;
    end else begin
      sat_add = s[7:0];
    end
  endfunction

  // half resolution halves the raw count, keeping the sign
  function automatic logic [7:0] res_scale(input logic [7:0] v, input logic full);
    res_scale = full ? v : {v[7], v[7:1]};
  endfunction

  // raw pins go through the debouncer
  assign kif.raw = {option_select_one_pin_n, option_select_zero_pin_n,
                    middle_key_input_n, right_key_input_n, left_key_input_n};

  key_debounce #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
  ) u_debounce (
    .mclk(mclk),
    .rst(rst),
    .keys(kif.filter)
  );

  // key state from filtered levels, inverted so a grounded pin reads 1
  always_comb begin
    keys_pressed = ~kif.level; // R6 R5
    keys_now = keys_pressed;
    if (!five_key_mode) begin
      keys_now[`FIFTH_KEY_BIT] = 1'b0; // R3
      keys_now[`FOURTH_KEY_BIT] = 1'b0; // R4
    end
  end

  // scaled motion and accumulation of this cycle's step
  always_comb begin
    step_x = res_scale(motion_dx, full_resolution); // R11
    step_y = res_scale(motion_dy, full_resolution); // R11
    sum_x = q.acc_x;
    sum_y = q.acc_y;
    pending_now = q.acc_pending;
    if (motion_valid) begin
      sum_x = sat_add(q.acc_x, step_x); // R10
      sum_y = sat_add(q.acc_y, step_y); // R10
      pending_now = q.acc_pending || (step_x != 8'h00) || (step_y != 8'h00);
    end
    ep_free = !q.ep_full || report_taken;
  end

  // next state: endpoint loading, accumulation and register reads
  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    d.surface_quality = surface_quality_in;
    d.acc_x = sum_x;
    d.acc_y = sum_y;
    d.acc_pending = pending_now;
    // a taken report empties the endpoint
    if (report_taken) begin
      d.ep_full = 1'b0; // R15
    end
    // an empty endpoint takes the accumulated move or a key change
    if (ep_free && (pending_now || keys_now != q.ep_keys)) begin
      d.ep_full = 1'b1; // R1 R2
      d.ep_keys = keys_now;
      d.ep_x = sum_x; // R8
      d.ep_y = sum_y; // R9
      d.acc_x = 8'h00;
      d.acc_y = 8'h00;
      d.acc_pending = 1'b0;
    end
    // register read answer, one cycle after the request
    if (reg_rd_req) begin // R14
      d.rvalid = 1'b1;
      unique case (reg_addr)
        `MOTION_STATUS_ADDR: begin
          d.rdata = {q.ep_full, 2'b00, keys_now}; // R1 R7
        end
        `X_DISPLACEMENT_ADDR: begin
          d.rdata = q.ep_x; // R8
          d.x_read_seen = 1'b1; // R12
        end
        `Y_DISPLACEMENT_ADDR: begin
          d.rdata = q.x_read_seen ? q.ep_y : 8'h00; // R12 R9
          d.x_read_seen = 1'b0; // R12
        end
        `SURFACE_QUALITY_ADDR: begin
          d.rdata = q.surface_quality;
        end
        default: begin
          d.rdata = `UNMAPPED_READ_VALUE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '{ep_full: 1'b0, ep_keys: 5'h00, ep_x: `DISPLACEMENT_RESET,
             ep_y: `DISPLACEMENT_RESET, acc_x: 8'h00, acc_y: 8'h00,
             acc_pending: 1'b0, x_read_seen: 1'b0,
             surface_quality: `SURFACE_QUALITY_RESET, rdata: 8'h00, rvalid: 1'b0};
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = q.rdata;
  assign reg_rdata_valid = q.rvalid;
  assign report_valid = q.ep_full;
  assign report_keys = q.ep_keys;
  assign report_x = q.ep_x;
  assign report_y = q.ep_y;

  // read request sequences
  sequence s_status_read;
    reg_rd_req && reg_addr == `MOTION_STATUS_ADDR;
  endsequence

  sequence s_x_read;
    reg_rd_req && reg_addr == `X_DISPLACEMENT_ADDR;
  endsequence

  sequence s_y_read;
    reg_rd_req && reg_addr == `Y_DISPLACEMENT_ADDR;
  endsequence

  sequence s_no_y_read;
    !(reg_rd_req && reg_addr == `Y_DISPLACEMENT_ADDR);
  endsequence

  AST_MOVE_FLAG_READ: assert property (@(posedge mclk) disable iff (rst) // R1
    s_status_read |=> reg_rdata_valid && reg_rdata[`MOVE_FLAG_BIT] == $past(report_valid))
    else $error("movement flag does not match endpoint state");

  AST_FLAG_MEANS_DATA: assert property (@(posedge mclk) disable iff (rst) // R2
    $rose(report_valid) |-> $past(pending_now) || $past(keys_now) != $past(q.ep_keys))
    else $error("endpoint filled with nothing to report");

  AST_FIFTH_KEY: assert property (@(posedge mclk) disable iff (rst) // R3
    s_status_read and five_key_mode |=> reg_rdata[`FIFTH_KEY_BIT] == !$past(kif.level[4]))
    else $error("fifth key bit does not follow option-one level");

  AST_FOURTH_KEY: assert property (@(posedge mclk) disable iff (rst) // R4
    s_status_read and five_key_mode |=> reg_rdata[`FOURTH_KEY_BIT] == !$past(kif.level[3]))
    else $error("fourth key bit does not follow option-zero level");

  AST_PRIMARY_KEYS: assert property (@(posedge mclk) disable iff (rst) // R5
    s_status_read |=> reg_rdata[`PRIMARY_KEYS_MSB:0] == ~$past(kif.level[2:0]))
    else $error("primary key bits not inverted filtered levels");

  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (rst) // R7
    s_status_read |=> reg_rdata[`RESERVED_HI_BIT:`RESERVED_LO_BIT] == 2'b00)
    else $error("reserved status bits not zero");

  AST_X_VALUE: assert property (@(posedge mclk) disable iff (rst) // R8
    s_x_read |=> reg_rdata == $past(report_x))
    else $error("x register does not show endpoint x");

  AST_Y_AFTER_X: assert property (@(posedge mclk) disable iff (rst) // R9
    s_x_read ##1 s_no_y_read ##1 s_y_read |=> reg_rdata == $past(report_y))
    else $error("y read after x does not show endpoint y");

  AST_Y_WITHOUT_X: assert property (@(posedge mclk) disable iff (rst) // R12
    s_y_read and !q.x_read_seen |=> reg_rdata == 8'h00)
    else $error("y read without x read returned nonzero");

  AST_FLAG_CLEARS: assert property (@(posedge mclk) disable iff (rst) // R15
    report_taken && !pending_now && keys_now == q.ep_keys |=> !report_valid)
    else $error("movement flag stayed set after report taken");

  AST_HALF_RES: assert property (@(posedge mclk) disable iff (rst) // R11
    motion_valid && !full_resolution && !q.acc_pending && q.acc_x == 8'h00 && ep_free
    && motion_dx[7:1] != 7'h00
    |=> report_x == {$past(motion_dx[7]), $past(motion_dx[7:1])})
    else $error("half resolution step not halved");

  // further request and endpoint sequences
  sequence s_unmapped_read;
    reg_rd_req && !(reg_addr inside {`MOTION_STATUS_ADDR, `X_DISPLACEMENT_ADDR,
                                     `Y_DISPLACEMENT_ADDR, `SURFACE_QUALITY_ADDR});
  endsequence

  sequence s_endpoint_hold;
    report_valid && !report_taken;
  endsequence

  // every read request gets exactly one answer pulse, one cycle later
  AST_READ_ANSWER: assert property (@(posedge mclk) disable iff (rst) // R14
    reg_rd_req |=> reg_rdata_valid)
    else $error("read request without answer");

  AST_NO_SPURIOUS_ANSWER: assert property (@(posedge mclk) disable iff (rst) // R14
    !reg_rd_req |=> !reg_rdata_valid)
    else $error("read answer without request");

  AST_UNMAPPED_ZERO: assert property (@(posedge mclk) disable iff (rst) // R14
    s_unmapped_read |=> reg_rdata == `UNMAPPED_READ_VALUE)
    else $error("unmapped read returned nonzero");

  // quality register lags its input by one register stage
  AST_SURFACE_QUALITY_READ: assert property (@(posedge mclk) disable iff (rst) // R14
    reg_rd_req && reg_addr == `SURFACE_QUALITY_ADDR && !$past(rst)
    |=> reg_rdata == $past(surface_quality_in, 2))
    else $error("quality read does not show sampled input");

  // three-key mode keeps the shared option pins out of the status byte
  AST_THREE_KEY_MASK: assert property (@(posedge mclk) disable iff (rst) // R3
    s_status_read and !five_key_mode
    |=> reg_rdata[`FIFTH_KEY_BIT:`FOURTH_KEY_BIT] == 2'b00)
    else $error("option key bits set in three-key mode");

  // a full endpoint keeps its flag and contents until the host takes it
  AST_FLAG_HOLDS: assert property (@(posedge mclk) disable iff (rst) // R2
    s_endpoint_hold |=> report_valid)
    else $error("movement flag dropped without a taken report");

  AST_REPORT_STABLE: assert property (@(posedge mclk) disable iff (rst) // R8
    s_endpoint_hold |=> $stable(report_x) && $stable(report_y) && $stable(report_keys))
    else $error("queued report changed before it was taken");

  // an empty endpoint loads at once on movement or on a key change
  AST_FLAG_SETS: assert property (@(posedge mclk) disable iff (rst) // R1
    motion_valid && full_resolution && motion_dx != 8'h00 && !report_valid
    |=> report_valid)
    else $error("movement did not set the flag");

  AST_KEYS_LOAD: assert property (@(posedge mclk) disable iff (rst) // R1
    !report_valid && keys_now != q.ep_keys
    |=> report_valid && report_keys == $past(keys_now))
    else $error("key change not loaded into empty endpoint");

  // accumulation saturates instead of wrapping while the endpoint is full
  AST_SATURATE: assert property (@(posedge mclk) disable iff (rst) // R10
    motion_valid && full_resolution && !motion_dx[7] && q.acc_x == 8'h7f
    && report_valid && !report_taken |=> q.acc_x == 8'h7f)
    else $error("positive x accumulation wrapped");

  // a load hands the whole accumulation over and starts afresh
  AST_LOAD_CLEARS: assert property (@(posedge mclk) disable iff (rst) // R8
    $rose(report_valid) |-> q.acc_x == 8'h00 && q.acc_y == 8'h00 && !q.acc_pending)
    else $error("accumulator not cleared by endpoint load");

  // a y read disarms the pair so a later lone y read returns zero
  AST_X_ARM_CLEAR: assert property (@(posedge mclk) disable iff (rst) // R12
    s_y_read |=> !q.x_read_seen)
    else $error("y read left the pair armed");

endmodule

`default_nettype wire

// >>> motion_regs_params.svh
// constants of the motion, key status and displacement register group
// assumes a 250 MHz mclk; included by bare name wherever needed
`ifndef MOTION_REGS_PARAMS_SVH
`define MOTION_REGS_PARAMS_SVH

// register addresses on the usb register request path
`define MOTION_STATUS_ADDR 8'h02
`define X_DISPLACEMENT_ADDR 8'h03
`define Y_DISPLACEMENT_ADDR 8'h04
`define SURFACE_QUALITY_ADDR 8'h05

// reset values
`define DISPLACEMENT_RESET 8'h00
`define SURFACE_QUALITY_RESET 8'h00
`define UNMAPPED_READ_VALUE 8'h00
`define KEY_IDLE_LEVEL 5'h1f

// motion status field positions
`define MOVE_FLAG_BIT 7
`define RESERVED_HI_BIT 6
`define RESERVED_LO_BIT 5
`define FIFTH_KEY_BIT 4
`define FOURTH_KEY_BIT 3
`define PRIMARY_KEYS_MSB 2

// debounce timing
`define MCLK_PERIOD_NS 4
`define DEBOUNCE_TIME_US 5000
`define DEBOUNCE_CYCLES (`DEBOUNCE_TIME_US * 1000 / `MCLK_PERIOD_NS)

`endif

// >>> motion_regs_pkg.sv
// types shared by the motion register group
// assumes the constants header supplies addresses and field positions
`default_nettype none

package motion_regs_pkg;

  // number of key inputs handled by the debouncer
  localparam int KEY_COUNT = 5;

  // whole state of the register group
  typedef struct packed {
    logic ep_full;
    logic [4:0] ep_keys;
    logic [7:0] ep_x;
    logic [7:0] ep_y;
    logic [7:0] acc_x;
    logic [7:0] acc_y;
    logic acc_pending;
    logic x_read_seen;
    logic [7:0] surface_quality;
    logic [7:0] rdata;
    logic rvalid;
  } regs_state_t;

endpackage

`default_nettype wire

// >>> key_debounce_if.sv
// carries raw key pin levels to the debouncer and filtered levels back
// assumes both ends run on the same mclk
`timescale 1ns/1ns
`default_nettype none

interface key_debounce_if;
  logic [4:0] raw;
  logic [4:0] level;
  modport filter (input raw, output level);
  modport user (output raw, input level);
endinterface

`default_nettype wire

// >>> key_debounce.sv
// debounce filter for the five key pins
// assumes pins are already synchronous to mclk
`timescale 1ns/1ns
`default_nettype none
`include "motion_regs_params.svh"

module key_debounce #(
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  key_debounce_if.filter keys
);
  localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(DEBOUNCE_CYCLES - 1);

  typedef struct packed {
    logic [4:0] level;
    logic [4:0][CW-1:0] cnt;
  } deb_state_t;

  deb_state_t q;
  deb_state_t d;

  // a level moves only after the pin held its new value for the full time
  always_comb begin
    d = q;
    for (int i = 0; i < motion_regs_pkg::KEY_COUNT; i++) begin
      if (keys.raw[i] != q.level[i]) begin
        if (q.cnt[i] == LAST) begin
          d.level[i] = keys.raw[i];
          d.cnt[i] = '0;
        end else begin
          d.cnt[i] = q.cnt[i] + CW'(1);
        end
      end else begin
        d.cnt[i] = '0;
      end
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '{level: `KEY_IDLE_LEVEL, cnt: '0};
    end else begin
      q <= d;
    end
  end

  assign keys.level = q.level;

  // a filtered level may only change once the count has run out
  AST_DEBOUNCE_HOLD: assert property (@(posedge mclk) disable iff (rst) // R6
    $changed(q.level) |-> $past(q.cnt) != '0 || LAST == '0)
    else $error("key level changed without a full debounce count");

endmodule

`default_nettype wire

// >>> usb_host_model.sv
// usb host model: issues register reads and collects endpoint reports
// assumes the block answers a read exactly one mclk after the request edge
`timescale 1ns/1ns
`default_nettype none
`include "motion_regs_params.svh"

module usb_host_model (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rdata_valid,
  input wire logic report_valid,
  output logic reg_rd_req,
  output logic [7:0] reg_addr,
  output logic report_taken
);
  // idle bus at time zero
  initial begin
    reg_rd_req = 1'b0;
    reg_addr = 8'h00;
    report_taken = 1'b0;
  end

  // one register read request; data only counts while valid is high
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge mclk);
    reg_rd_req <= 1'b1;
    reg_addr <= addr;
    @(posedge mclk);
    reg_rd_req <= 1'b0;
    #1;
    data = (reg_rdata_valid === 1'b1) ? reg_rdata : 8'hxx;
  endtask

  // displacement pair, x always first so y is not zeroed
  task automatic rd_xy(output logic [7:0] x, output logic [7:0] y);
    rd(`X_DISPLACEMENT_ADDR, x);
    rd(`Y_DISPLACEMENT_ADDR, y);
  endtask

  // collect the pending report, only while the endpoint holds one
  task automatic take();
    @(posedge mclk);
    if (report_valid === 1'b1) begin
      report_taken <= 1'b1;
      @(posedge mclk);
      report_taken <= 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// >>> motion_button_status_regs_tb.sv
// testbench for the motion, key status and displacement registers
// assumes the usb host model and a shortened debounce count of 4
`timescale 1ns/1ns
`default_nettype none
`include "motion_regs_params.svh"

module motion_button_status_regs_tb;
  localparam logic [7:0] stat = `MOTION_STATUS_ADDR;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] keys_n = 5'h1f;
  logic five_key_mode = 1'b0;
  logic full_resolution = 1'b1;
  logic motion_valid = 1'b0;
  logic [7:0] dx = 8'h00;
  logic [7:0] dy = 8'h00;
  logic [7:0] sq = 8'h5a;
  logic req, taken, rv, report_valid;
  logic [7:0] addr, rdata, report_x, report_y;
  logic [4:0] report_keys;
  int bad_count = 0;
  int compares = 0;

  motion_status_regs #(.DEBOUNCE_CYCLES(4)) dut (
    .mclk(mclk), .rst(rst),
    .left_key_input_n(keys_n[0]), .right_key_input_n(keys_n[1]),
    .middle_key_input_n(keys_n[2]), .option_select_zero_pin_n(keys_n[3]),
    .option_select_one_pin_n(keys_n[4]), .five_key_mode(five_key_mode),
    .full_resolution(full_resolution), .motion_valid(motion_valid),
    .motion_dx(dx), .motion_dy(dy), .surface_quality_in(sq),
    .report_taken(taken), .reg_rd_req(req), .reg_addr(addr),
    .reg_rdata(rdata), .reg_rdata_valid(rv), .report_valid(report_valid),
    .report_keys(report_keys), .report_x(report_x), .report_y(report_y)
  );

  usb_host_model host (
    .mclk(mclk), .reg_rdata(rdata), .reg_rdata_valid(rv),
    .report_valid(report_valid), .reg_rd_req(req), .reg_addr(addr),
    .report_taken(taken)
  );

  // free running clock
  initial begin
    forever #2 mclk = ~mclk;
  end

  // verdict and end of run
  task automatic wrap_up();
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // compare and report a mismatch
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read one register and compare
  task automatic expect_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask

  // read the displacement pair and compare
  task automatic expect_xy(input logic [7:0] ex, input logic [7:0] ey);
    logic [7:0] x, y;
    host.rd_xy(x, y);
    chk(x, ex);
    chk(y, ey);
  endtask

  // one motion step, then time for the report to load
  task automatic mv(input logic [7:0] sx, input logic [7:0] sy);
    @(posedge mclk);
    motion_valid <= 1'b1;
    dx <= sx;
    dy <= sy;
    @(posedge mclk);
    motion_valid <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    expect_rd(stat, 8'h00);
    expect_xy(`DISPLACEMENT_RESET, `DISPLACEMENT_RESET);
    expect_rd(`SURFACE_QUALITY_ADDR, 8'h5a);
    expect_rd(8'h3f, `UNMAPPED_READ_VALUE);
    mv(8'h03, 8'hff);
    expect_rd(stat, 8'h80);
    chk(report_x, 8'h03);
    chk(report_y, 8'hff);
    expect_xy(8'h03, 8'hff);
    expect_rd(`Y_DISPLACEMENT_ADDR, 8'h00);
    host.take();
    repeat (2) @(posedge mclk);
    expect_rd(stat, 8'h00);
    // moves while full accumulate and saturate at the positive limit
    mv(8'h10, 8'h00);
    repeat (3) mv(8'h70, 8'h00);
    host.take();
    expect_xy(8'h7f, 8'h00);
    host.take();
    // half resolution halves the step; quality follows its input
    @(posedge mclk) full_resolution <= 1'b0;
    sq <= 8'h3c;
    mv(8'hf8, 8'h06);
    expect_xy(8'hfc, 8'h03);
    expect_rd(`SURFACE_QUALITY_ADDR, 8'h3c);
    host.take();
    // left and option-zero pressed while in three-key mode
    keys_n <= 5'h16;
    repeat (12) @(posedge mclk);
    expect_rd(stat, 8'h81);
    @(posedge mclk) five_key_mode <= 1'b1;
    expect_rd(stat, 8'h89);
    @(posedge mclk) keys_n <= 5'h06;
    repeat (12) @(posedge mclk);
    expect_rd(stat, 8'h99);
    // raw press not yet settled must not show
    @(posedge mclk) keys_n <= 5'h00;
    expect_rd(stat, 8'h99);
    repeat (12) @(posedge mclk);
    expect_rd(stat, 8'h9f);
    // keys changed while full, so taking reloads the report
    host.take();
    repeat (3) @(posedge mclk);
    expect_rd(stat, 8'h9f);
    chk({3'h0, report_keys}, 8'h1f);
    host.take();
    repeat (3) @(posedge mclk);
    expect_rd(stat, 8'h1f);
    wrap_up();
  end

  // watchdog against a hang
  initial begin
    #20000;
    bad_count++;
    $display("Error at %0t: timeout", $time);
    wrap_up();
  end
endmodule

`default_nettype wire
